// >>> core/sie_pkg.sv
/*
  Shared constants for the stage interrupt enable block: register
  offsets, field widths and reset values.
  Assumes the word-wide register port of the serial interface front end.
*/
`default_nettype none

package sie_pkg;

  // register port shape
  localparam int unsigned ADDR_W     = 10;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned STAGE_N    = 8;

  // register offsets as seen by the host
  localparam logic [9:0] OFS_LOW_EN    = 10'h005;
  localparam logic [9:0] OFS_HIGH_EN   = 10'h006;
  localparam logic [9:0] OFS_DONE_EN   = 10'h007;
  localparam logic [9:0] OFS_LOW_FLAG  = 10'h008;
  localparam logic [9:0] OFS_HIGH_FLAG = 10'h009;
  localparam logic [9:0] OFS_DONE_FLAG = 10'h00a;

  // field layout: stage bits sit at the bottom of each word
  localparam int unsigned STAGE_LSB  = 0;
  localparam int unsigned STAGE_MSB  = 7;

  // reset values
  localparam logic [7:0]  ENABLE_RST = 8'h00;
  localparam logic [7:0]  FLAG_RST   = 8'h00;
  localparam logic [15:0] RDATA_RST  = 16'h0000;
  localparam logic [7:0]  UNUSED_RD  = 8'h00;

endpackage : sie_pkg

`default_nettype wire

// >>> core/sie_flag_bank.sv
/*
  Bank of sticky per-stage status flags with clear on read.
  Assumes an active-low reset whose release is already retimed to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module sie_flag_bank
  import sie_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // event side
  input  wire logic [WIDTH-1:0] set_in,
  // host side
  input  wire logic             clear_in,
  output logic      [WIDTH-1:0] flag_out
);

  logic [WIDTH-1:0] flag_reg;
  logic [WIDTH-1:0] flag_next;

  // a read clears, but an event present now wins so nothing is lost
  always_comb begin
    flag_next = set_in | (flag_reg & ~{WIDTH{clear_in}});
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_out = flag_reg;

endmodule : sie_flag_bank

`default_nettype wire

// >>> core/sie_top.sv
/*
  Per-stage interrupt enables, status flags and the active-low
  interrupt pin of an eight-stage conversion sequencer.
  Assumes the serial front end presents one-cycle read and write
  strobes with a word address, and the sequencer presents per-stage
  limit levels and completion pulses, all synchronous to SYS_CLK.
  Read data follows a read strobe by one cycle and then holds until
  the next read; the interrupt pin follows a stage event by two cycles.
  The front end leaves the register port idle for the first two cycles
  after RST_N rises, while the local reset copy is still asserted.
  Writes to status words or to unmapped words are ignored, and reads of
  unmapped words return zero.
  Stage n always sits at bit n of every word.
*/
`timescale 1ns/1ps
`default_nettype none

module sie_top
  import sie_pkg::*;
(
  // clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  // register port from the serial front end
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic              REG_WR,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  input  wire logic              REG_RD,
  output logic      [DATA_W-1:0] REG_RDATA,
  output logic                   REG_RVALID,
  // stage events from the sequencer
  input  wire logic [STAGE_N-1:0] STAGE_LOW_EXCEED,
  input  wire logic [STAGE_N-1:0] STAGE_HIGH_EXCEED,
  input  wire logic [STAGE_N-1:0] STAGE_DONE,
  // interrupt pin
  output logic                   INT_N
);

  // reset synchroniser
  logic                rst_meta_reg;
  logic                rst_sync_reg;
  // enable words, one bit per stage
  logic [STAGE_N-1:0]  stage_low_irq_enable;
  logic [STAGE_N-1:0]  stage_high_irq_enable;
  logic [STAGE_N-1:0]  stage_done_irq_enable;
  // write decode for the enable words
  logic                wr_low_en;
  logic                wr_high_en;
  logic                wr_done_en;
  // sticky status flags, one bit per stage
  logic [STAGE_N-1:0]  stage_low_limit_flag;
  logic [STAGE_N-1:0]  stage_high_limit_flag;
  logic [STAGE_N-1:0]  stage_done_flag;
  // read path
  logic                rd_low_flag;
  logic                rd_high_flag;
  logic                rd_done_flag;
  logic [STAGE_N-1:0]  rd_word;
  logic [DATA_W-1:0]   rdata_reg;
  logic                rvalid_reg;
  // interrupt path
  logic [STAGE_N-1:0]  high_pending;
  logic [STAGE_N-1:0]  done_pending;
  logic [STAGE_N-1:0]  low_pending;
  logic [STAGE_N-1:0]  pending;
  logic                int_n_next;
  logic                int_n_reg;

  // reset released through two flops, asserted at once
  // the release is retimed so no flop sees it near its clock edge
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // write strobes per enable word; flag words and unmapped words take none
  // so a stray write can never disturb a status bit
  assign wr_low_en  = REG_WR && (REG_ADDR == OFS_LOW_EN);
  assign wr_high_en = REG_WR && (REG_ADDR == OFS_HIGH_EN);
  assign wr_done_en = REG_WR && (REG_ADDR == OFS_DONE_EN);

  // low-threshold enables; bits above stage 7 are not stored
  always_ff @(posedge SYS_CLK or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      stage_low_irq_enable <= ENABLE_RST;
    end else if (wr_low_en) begin
      stage_low_irq_enable <= REG_WDATA[STAGE_MSB:STAGE_LSB];
    end
  end

  // high-threshold enables; the host keeps bits 15 to 8 at zero
  always_ff @(posedge SYS_CLK or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      stage_high_irq_enable <= ENABLE_RST;
    end else if (wr_high_en) begin
      stage_high_irq_enable <= REG_WDATA[STAGE_MSB:STAGE_LSB];
    end
  end

  // completion enables; a stray upper bit is simply dropped
  always_ff @(posedge SYS_CLK or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      stage_done_irq_enable <= ENABLE_RST;
    end else if (wr_done_en) begin
      stage_done_irq_enable <= REG_WDATA[STAGE_MSB:STAGE_LSB];
    end
  end

  // a read of a status word clears it after its value is captured;
  // an event in the same cycle still wins inside the flag bank
  assign rd_low_flag  = REG_RD && (REG_ADDR == OFS_LOW_FLAG);
  assign rd_high_flag = REG_RD && (REG_ADDR == OFS_HIGH_FLAG);
  assign rd_done_flag = REG_RD && (REG_ADDR == OFS_DONE_FLAG);

  // limit levels re-set their flag every cycle they hold
  // low limits reach the pin only through their own enable word
  sie_flag_bank #(.WIDTH(STAGE_N)) u_low_flags (
    .clk      (SYS_CLK),
    .rst_n    (rst_sync_reg),
    .set_in   (STAGE_LOW_EXCEED),
    .clear_in (rd_low_flag),
    .flag_out (stage_low_limit_flag)
  );

  // high limits are levels too; a read while one holds leaves it set
  sie_flag_bank #(.WIDTH(STAGE_N)) u_high_flags (
    .clk      (SYS_CLK),
    .rst_n    (rst_sync_reg),
    .set_in   (STAGE_HIGH_EXCEED),
    .clear_in (rd_high_flag),
    .flag_out (stage_high_limit_flag)
  );

  // completion pulses last one cycle; the flag keeps them for the host
  sie_flag_bank #(.WIDTH(STAGE_N)) u_done_flags (
    .clk      (SYS_CLK),
    .rst_n    (rst_sync_reg),
    .set_in   (STAGE_DONE),
    .clear_in (rd_done_flag),
    .flag_out (stage_done_flag)
  );

  // read mux; unmapped addresses and unused bits read zero
  // status words clear as a whole, so the host must act on every bit read
  always_comb begin
    unique case (REG_ADDR)
      OFS_LOW_EN:    rd_word = stage_low_irq_enable;
      OFS_HIGH_EN:   rd_word = stage_high_irq_enable;
      OFS_DONE_EN:   rd_word = stage_done_irq_enable;
      OFS_LOW_FLAG:  rd_word = stage_low_limit_flag;
      OFS_HIGH_FLAG: rd_word = stage_high_limit_flag;
      OFS_DONE_FLAG: rd_word = stage_done_flag;
      default:       rd_word = '0;
    endcase
  end

  // read data held until the next read, so a slow front end can fetch it late
  always_ff @(posedge SYS_CLK or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rdata_reg <= RDATA_RST;
    end else if (REG_RD) begin
      rdata_reg <= {UNUSED_RD, rd_word};
    end
  end

  // answer strobe, one cycle after every read
  always_ff @(posedge SYS_CLK or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= REG_RD;
    end
  end

  // each source masked by its own enable; a zero enable hides only that source of its stage from the pin
  assign high_pending = stage_high_limit_flag & stage_high_irq_enable;
  assign done_pending = stage_done_flag & stage_done_irq_enable;
  assign low_pending  = stage_low_limit_flag & stage_low_irq_enable;

  // any enabled stage still pending keeps the pin asserted
  assign pending = high_pending | done_pending | low_pending;

  // next pin level: low while any enabled stage is pending
  always_comb begin
    int_n_next = ~(|pending);
  end

  // registered pin so it never glitches on the board;
  // trade-off: one more cycle of latency for a clean level
  always_ff @(posedge SYS_CLK or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      int_n_reg <= 1'b1;
    end else begin
      int_n_reg <= int_n_next;
    end
  end

  // outputs come straight from flops
  assign REG_RDATA  = rdata_reg;
  assign REG_RVALID = rvalid_reg;
  assign INT_N      = int_n_reg;

endmodule : sie_top

`default_nettype wire

// >>> tb/sie_top_sva.sv
/* port checker for sie_top: read answers, pin timing
   assumes binding onto sie_top, one clock domain */
`timescale 1ns/1ps
`default_nettype none
module sie_top_sva
  import sie_pkg::*;
(
  // clock and reset
  input wire logic                SYS_CLK,
  input wire logic                RST_N,
  // register port
  input wire logic                REG_WR,
  input wire logic                REG_RD,
  input wire logic [ADDR_W-1:0]   REG_ADDR,
  input wire logic [DATA_W-1:0]   REG_WDATA,
  input wire logic [DATA_W-1:0]   REG_RDATA,
  input wire logic                REG_RVALID,
  // stage events and pin
  input wire logic [STAGE_N-1:0]  STAGE_LOW_EXCEED,
  input wire logic [STAGE_N-1:0]  STAGE_HIGH_EXCEED,
  input wire logic [STAGE_N-1:0]  STAGE_DONE,
  input wire logic                INT_N
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // register port answers
  chk_rd_answer: assert property (REG_RD |=> REG_RVALID) else $error("read unanswered");
  chk_rv_pulse: assert property (!REG_RD |=> !REG_RVALID) else $error("stray answer");
  chk_hi_zero: assert property (REG_RVALID |-> REG_RDATA[15:8] == 8'h00) else $error("upper bits set");
  chk_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA)) else $error("read data moved");
  // pin moves only two cycles after a cause
  chk_int_fall: assert property ($fell(INT_N) |-> $past(REG_WR, 2) ||
    $past(|{STAGE_LOW_EXCEED, STAGE_HIGH_EXCEED, STAGE_DONE}, 2)) else $error("pin fell alone");
  chk_int_rise: assert property ($rose(INT_N) |-> $past(REG_RD, 2) || $past(REG_WR, 2))
    else $error("pin rose alone");
  chk_done_fire: assert property ((REG_WR && REG_ADDR == OFS_DONE_EN) ##1
    (!REG_WR && (STAGE_DONE & $past(REG_WDATA[7:0])) != 8'h00) |-> ##2 !INT_N)
    else $error("done missed");
  chk_write_back: assert property ((REG_WR && (REG_ADDR == OFS_HIGH_EN || REG_ADDR == OFS_DONE_EN)) ##1
    (REG_RD && !REG_WR && REG_ADDR == $past(REG_ADDR)) |=> REG_RDATA == {8'h00, $past(REG_WDATA[7:0], 2)})
    else $error("enable lost");
endmodule : sie_top_sva
bind sie_top sie_top_sva chk_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RVALID(REG_RVALID), .INT_N(INT_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .STAGE_LOW_EXCEED(STAGE_LOW_EXCEED), .STAGE_HIGH_EXCEED(STAGE_HIGH_EXCEED), .STAGE_DONE(STAGE_DONE));
`default_nettype wire

// >>> tb/sie_host.sv
/* host model on the register port
   assumes the bench calls its tasks at clock edges */
`timescale 1ns/1ps
`default_nettype none
module sie_host
  import sie_pkg::*;
(
  // clock
  input  wire logic              clk,
  // register port strobes
  output var  logic              wr,
  output var  logic              rd,
  // address and write data
  output var  logic [ADDR_W-1:0] addr,
  output var  logic [DATA_W-1:0] wdata
);
  initial {wr, rd, addr, wdata} = '0;
  // strobes stay up so accesses can run back to back
  task automatic acc(input logic w, r, input logic [9:0] a, input logic [7:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= {8'h00, d};
    @(posedge clk);
  endtask : acc
  // released lines flip so no stale value lingers
  task automatic idle();
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= ~addr;
    wdata <= ~wdata;
    @(posedge clk);
  endtask : idle
endmodule : sie_host
`default_nettype wire

// >>> tb/stage_interrupt_enables_tb.sv
/* self-checking bench for sie_top
   assumes checker and host model compiled first */
`timescale 1ns/1ps
`default_nettype none
module stage_interrupt_enables_tb import sie_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, wr, rd, rvalid, int_n;
  logic [9:0] addr;
  logic [15:0] wdata, rdata, exp_q[$];
  logic [7:0] lo = 8'h00, hi = 8'h00, dn = 8'h00, e;
  logic [31:0] seed = 32'h0001108c;
  int fails = 0, samples_checked = 0;
  sie_host host_u (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata));
  sie_top dut_u (.SYS_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
    .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid), .STAGE_LOW_EXCEED(lo),
    .STAGE_HIGH_EXCEED(hi), .STAGE_DONE(dn), .INT_N(int_n));
  always #2.5 clk = ~clk;
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  task automatic chk(input logic [15:0] got, want);
    samples_checked++;
    if (got !== want) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // note the expected word, then read
  task automatic rd_x(input logic [9:0] a, input logic [15:0] x);
    exp_q.push_back(x);
    host_u.acc(1'b0, 1'b1, a, 8'h00);
    host_u.idle();
  endtask : rd_x
  // event pattern, then the fixed two-cycle pin latency
  task automatic ev(input logic [7:0] l, h, d);
    lo <= l;
    hi <= h;
    dn <= d;
    @(posedge clk);
    dn <= 8'h00;
    repeat (2) @(posedge clk);
  endtask : ev
  // answers compared oldest first
  always @(posedge clk)
    if (rvalid === 1'b1) chk(rdata, exp_q.pop_front());
  // hang guard, well past the expected run
  initial begin
    #20000;
    fails++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_x(OFS_HIGH_EN, 16'h0000);
    rd_x(OFS_DONE_EN, 16'h0000);
    rd_x(10'h3ff, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      seed = nx(seed);
      e = seed[7:0];
      host_u.acc(1'b1, 1'b0, i ? OFS_DONE_EN : OFS_HIGH_EN, e);
      rd_x(i ? OFS_DONE_EN : OFS_HIGH_EN, {8'h00, e});
    end
    ev(8'h00, 8'h00, ~e);
    chk({15'h0, int_n}, 16'h0001);
    host_u.acc(1'b1, 1'b0, OFS_DONE_EN, 8'h08);
    fork
      host_u.idle();
      ev(8'h00, 8'h00, 8'h08);
    join
    chk({15'h0, int_n}, 16'h0000);
    rd_x(OFS_DONE_FLAG, {8'h00, ~e | 8'h08});
    @(posedge clk);
    chk({15'h0, int_n}, 16'h0001);
    rd_x(OFS_DONE_FLAG, 16'h0000);
    seed = nx(seed);
    e = seed[7:0] | 8'h01;
    host_u.acc(1'b1, 1'b0, OFS_HIGH_EN, e);
    host_u.idle();
    ev(seed[15:8], e, 8'h00);
    chk({15'h0, int_n}, 16'h0000);
    rd_x(OFS_HIGH_FLAG, {8'h00, e});
    rd_x(OFS_HIGH_FLAG, {8'h00, e});
    rd_x(OFS_LOW_FLAG, {8'h00, seed[15:8]});
    ev(8'h00, 8'h00, 8'h00);
    rd_x(OFS_HIGH_FLAG, {8'h00, e});
    rd_x(OFS_HIGH_FLAG, 16'h0000);
    @(posedge clk);
    chk({15'h0, int_n}, 16'h0001);
    host_u.acc(1'b1, 1'b0, OFS_LOW_EN, 8'h81);
    rd_x(OFS_LOW_EN, 16'h0081);
    ev(8'h01, 8'h00, 8'h00);
    chk({15'h0, int_n}, 16'h0000);
    rd_x(OFS_LOW_FLAG, {8'h00, seed[15:8] | 8'h01});
    ev(8'h00, 8'h00, 8'h00);
    rd_x(OFS_LOW_FLAG, 16'h0001);
    @(posedge clk);
    chk({15'h0, int_n}, 16'h0001);
    chk(16'(exp_q.size()), 16'h0000);
    summarize();
  end
endmodule : stage_interrupt_enables_tb
`default_nettype wire
